// ===== hdl/swsl_slave.sv
// single-wire bus slave front end: reset/presence, slots, addressing commands
`include "swsl_params.svh"

module swsl_slave #(
  parameter int unsigned RST_EXIT_CYC = `SWSL_RST_EXIT_CYC,
  parameter int unsigned RST_DET_STD_CYC = `SWSL_RST_DET_STD_CYC,
  parameter int unsigned PDL_STD_CYC = `SWSL_PDL_STD_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_line,
  output logic o_line_out,
  output logic o_line_oe_n,
  input wire logic [63:0] i_rom_id,
  input wire logic i_tx_en,
  input wire logic i_tx_bit,
  output logic o_tx_taken,
  output swsl_pkg::swsl_rx_t o_rx,
  output logic o_dev_active,
  output logic o_fast_speed_flag,
  output logic o_resume_select_flag,
  output logic o_reset_seen
);
  import swsl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state and next values

  swsl_state_t state;
  swsl_state_t next_state;
  logic fast_speed_flag;
  logic next_fast_speed_flag;
  logic fast_before;
  logic next_fast_before;
  logic resume_select_flag;
  logic next_resume_select_flag;
  logic od_match;
  logic next_od_match;
  logic id_miss;
  logic next_id_miss;
  logic line_q;
  logic [15:0] low_cnt;
  logic [15:0] next_low_cnt;
  logic [15:0] tmr;
  logic [15:0] next_tmr;
  logic slot_act;
  logic next_slot_act;
  logic [6:0] bit_cnt;
  logic [6:0] next_bit_cnt;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic drive_n;
  logic next_drive_n;
  logic tx_taken;
  logic next_tx_taken;
  swsl_rx_t rx;
  swsl_rx_t next_rx;
  logic reset_seen;
  logic next_reset_seen;

  swsl_timing_t tim;
  logic fall;
  logic rise;
  logic [7:0] byte_in;

  ////////////////////////////////////////////////////////////////////////////
  // timing set chosen by the fast flag

  // standard set unless fast flag is set
  always_comb begin
    if (fast_speed_flag) begin
      tim.rst_det = 16'(`SWSL_RST_DET_OD_CYC);
      tim.pres_delay = 16'(`SWSL_PDH_OD_CYC);
      tim.pres_low = 16'(`SWSL_PDL_OD_CYC);
      tim.sample = 16'(`SWSL_SAMPLE_OD_CYC);
      tim.drive = 16'(`SWSL_DRIVE_OD_CYC);
    end else begin
      tim.rst_det = 16'(RST_DET_STD_CYC);
      tim.pres_delay = 16'(`SWSL_PDH_STD_CYC);
      tim.pres_low = 16'(PDL_STD_CYC);
      tim.sample = 16'(`SWSL_SAMPLE_STD_CYC);
      tim.drive = 16'(`SWSL_DRIVE_STD_CYC);
    end
  end

  // edges of the line; our own presence pulse is not a slot edge
  assign fall = line_q && !i_line && state != SWSL_PRES_LOW;
  assign rise = !line_q && i_line;
  // incoming bit enters at the top, so bytes fill lsb first
  assign byte_in = {i_line, shreg[7:1]};

  ////////////////////////////////////////////////////////////////////////////
  // next-value logic for the whole sequencer

  always_comb begin
    next_state = state;
    next_fast_speed_flag = fast_speed_flag;
    next_fast_before = fast_before;
    next_resume_select_flag = resume_select_flag;
    next_od_match = od_match;
    next_id_miss = id_miss;
    next_tmr = tmr;
    next_slot_act = slot_act;
    next_bit_cnt = bit_cnt;
    next_shreg = shreg;
    next_drive_n = drive_n;
    next_tx_taken = 1'b0;
    next_rx.valid = 1'b0;
    next_rx.data = rx.data;
    next_reset_seen = 1'b0;
    // low time counter, saturating
    if (i_line) begin
      next_low_cnt = 16'h0000;
    end else if (low_cnt != 16'hffff) begin
      next_low_cnt = low_cnt + 16'h0001;
    end else begin
      next_low_cnt = low_cnt;
    end

    // slot timer: sample point and read drive end
    if (slot_act) begin
      next_tmr = tmr + 16'h0001;
      if (tmr == tim.drive) begin
        next_slot_act = 1'b0;
        next_drive_n = 1'b1;
      end
      if (tmr == tim.sample) begin
        next_shreg = byte_in;
        next_bit_cnt = bit_cnt + 7'h01;
        case (state)
          SWSL_ROM_CMD: begin
            if (bit_cnt[2:0] == 3'h7) begin
              next_bit_cnt = 7'h00;
              case (byte_in)
                `SWSL_CMD_SKIP: begin
                  next_state = SWSL_DEV_PHASE;
                  next_resume_select_flag = 1'b0;
                end
                `SWSL_CMD_RESUME: begin
                  if (resume_select_flag) begin
                    next_state = SWSL_DEV_PHASE;
                  end else begin
                    next_state = SWSL_WAIT_RESET;
                  end
                end
                `SWSL_CMD_OD_SKIP: begin
                  next_fast_speed_flag = 1'b1;
                  next_resume_select_flag = 1'b0;
                  next_state = SWSL_DEV_PHASE;
                end
                `SWSL_CMD_OD_MATCH: begin
                  next_fast_before = fast_speed_flag;
                  next_fast_speed_flag = 1'b1;
                  next_od_match = 1'b1;
                  next_id_miss = 1'b0;
                  next_state = SWSL_ID_MATCH;
                end
                `SWSL_CMD_MATCH: begin
                  next_od_match = 1'b0;
                  next_id_miss = 1'b0;
                  next_state = SWSL_ID_MATCH;
                end
                default: begin
                  next_state = SWSL_WAIT_RESET;
                end
              endcase
            end
          end
          SWSL_ID_MATCH: begin
            // compare bit by bit, lsb of identifier first
            if (i_line != i_rom_id[bit_cnt[5:0]]) begin
              next_id_miss = 1'b1;
            end
            if (bit_cnt == 7'(`SWSL_ID_BITS - 1)) begin
              next_bit_cnt = 7'h00;
              if (!id_miss && i_line == i_rom_id[bit_cnt[5:0]]) begin
                next_resume_select_flag = 1'b1;
                next_state = SWSL_DEV_PHASE;
              end else begin
                next_resume_select_flag = 1'b0;
                next_state = SWSL_WAIT_RESET;
                if (od_match) begin
                  next_fast_speed_flag = fast_before;
                end
              end
            end
          end
          SWSL_DEV_PHASE: begin
            if (bit_cnt[2:0] == 3'h7) begin
              next_bit_cnt = 7'h00;
              next_rx.valid = 1'b1;
              next_rx.data = byte_in;
            end
          end
          default: begin
            next_bit_cnt = 7'h00;
          end
        endcase
      end
    end

    // a falling edge opens a slot
    if (fall) begin
      next_slot_act = 1'b1;
      next_tmr = 16'h0000;
      if (state == SWSL_DEV_PHASE && i_tx_en) begin
        next_tx_taken = 1'b1;
        next_drive_n = i_tx_bit;
      end
    end

    // presence sequence
    case (state)
      SWSL_PRES_DELAY: begin
        next_tmr = tmr + 16'h0001;
        if (tmr >= tim.pres_delay) begin
          next_tmr = 16'h0000;
          next_drive_n = 1'b0;
          next_state = SWSL_PRES_LOW;
        end
      end
      SWSL_PRES_LOW: begin
        next_tmr = tmr + 16'h0001;
        if (tmr >= tim.pres_low) begin
          next_drive_n = 1'b1;
          next_bit_cnt = 7'h00;
          next_state = SWSL_ROM_CMD;
        end
      end
      default: begin
      end
    endcase

    // a long low ends the transaction; its length sets the speed
    if (rise && state != SWSL_PRES_LOW && low_cnt >= tim.rst_det) begin
      next_reset_seen = 1'b1;
      next_state = SWSL_PRES_DELAY;
      next_tmr = 16'h0000;
      next_slot_act = 1'b0;
      next_drive_n = 1'b1;
      next_bit_cnt = 7'h00;
      if (low_cnt >= 16'(RST_EXIT_CYC)) begin
        next_fast_speed_flag = 1'b0;
      end else begin
        // at fast speed a short reset keeps the flag; the
        // 80-480us band is left to the master to avoid
        next_fast_speed_flag = fast_speed_flag;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= SWSL_WAIT_RESET;
      fast_speed_flag <= 1'b0;
      fast_before <= 1'b0;
      resume_select_flag <= 1'b0;
      od_match <= 1'b0;
      id_miss <= 1'b0;
      line_q <= 1'b1;
      low_cnt <= 16'h0000;
      tmr <= 16'h0000;
      slot_act <= 1'b0;
      bit_cnt <= 7'h00;
      shreg <= 8'h00;
      drive_n <= 1'b1;
      tx_taken <= 1'b0;
      rx <= '0;
      reset_seen <= 1'b0;
    end else if (i_ce) begin
      state <= next_state;
      fast_speed_flag <= next_fast_speed_flag;
      fast_before <= next_fast_before;
      resume_select_flag <= next_resume_select_flag;
      od_match <= next_od_match;
      id_miss <= next_id_miss;
      line_q <= i_line;
      low_cnt <= next_low_cnt;
      tmr <= next_tmr;
      slot_act <= next_slot_act;
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      drive_n <= next_drive_n;
      tx_taken <= next_tx_taken;
      rx <= next_rx;
      reset_seen <= next_reset_seen;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs from flip-flops, except o_line_out which is tied to 0

  assign o_line_out = 1'b0;
  assign o_line_oe_n = drive_n;
  assign o_tx_taken = tx_taken;
  assign o_rx = rx;
  assign o_fast_speed_flag = fast_speed_flag;
  assign o_resume_select_flag = resume_select_flag;
  assign o_reset_seen = reset_seen;

  // device phase indicator
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_dev_active <= 1'b0;
    end else if (i_ce) begin
      o_dev_active <= (next_state == SWSL_DEV_PHASE);
    end
  end

endmodule

// ===== inc/swsl_params.svh
// constants for the single-wire slave front end: commands, timings, widths
`ifndef SWSL_PARAMS_SVH
`define SWSL_PARAMS_SVH

// clock rate in MHz, 10 ns period
`define SWSL_CLK_MHZ 100

// addressing command codes
`define SWSL_CMD_SKIP 8'hcc
`define SWSL_CMD_RESUME 8'ha5
`define SWSL_CMD_OD_SKIP 8'h3c
`define SWSL_CMD_OD_MATCH 8'h69
`define SWSL_CMD_MATCH 8'h55

// identifier length in bits
`define SWSL_ID_BITS 64

// reset low time thresholds in microseconds
`define SWSL_RST_EXIT_US 480
`define SWSL_RST_KEEP_US 80
`define SWSL_RST_DET_STD_US 240
`define SWSL_RST_DET_OD_US 48

// presence delay and presence low time in microseconds
`define SWSL_PDH_STD_US 30
`define SWSL_PDH_OD_US 3
`define SWSL_PDL_STD_US 120
`define SWSL_PDL_OD_US 12

// slot write sample point and read drive duration in microseconds
`define SWSL_SAMPLE_STD_US 30
`define SWSL_SAMPLE_OD_US 3
`define SWSL_DRIVE_STD_US 40
`define SWSL_DRIVE_OD_US 4

// microseconds to clock cycles (whole figures, no rounding needed)
`define SWSL_CYC(us) ((us) * `SWSL_CLK_MHZ)

// cycle counts
`define SWSL_RST_EXIT_CYC `SWSL_CYC(`SWSL_RST_EXIT_US)
`define SWSL_RST_KEEP_CYC `SWSL_CYC(`SWSL_RST_KEEP_US)
`define SWSL_RST_DET_STD_CYC `SWSL_CYC(`SWSL_RST_DET_STD_US)
`define SWSL_RST_DET_OD_CYC `SWSL_CYC(`SWSL_RST_DET_OD_US)
`define SWSL_PDH_STD_CYC `SWSL_CYC(`SWSL_PDH_STD_US)
`define SWSL_PDH_OD_CYC `SWSL_CYC(`SWSL_PDH_OD_US)
`define SWSL_PDL_STD_CYC `SWSL_CYC(`SWSL_PDL_STD_US)
`define SWSL_PDL_OD_CYC `SWSL_CYC(`SWSL_PDL_OD_US)
`define SWSL_SAMPLE_STD_CYC `SWSL_CYC(`SWSL_SAMPLE_STD_US)
`define SWSL_SAMPLE_OD_CYC `SWSL_CYC(`SWSL_SAMPLE_OD_US)
`define SWSL_DRIVE_STD_CYC `SWSL_CYC(`SWSL_DRIVE_STD_US)
`define SWSL_DRIVE_OD_CYC `SWSL_CYC(`SWSL_DRIVE_OD_US)

`endif

// ===== inc/swsl_pkg.sv
// types shared by the single-wire slave front end
package swsl_pkg;

  // sequencer states
  typedef enum logic [2:0] {
    SWSL_WAIT_RESET = 3'b000,
    SWSL_PRES_DELAY = 3'b001,
    SWSL_PRES_LOW = 3'b010,
    SWSL_ROM_CMD = 3'b011,
    SWSL_ID_MATCH = 3'b100,
    SWSL_DEV_PHASE = 3'b101
  } swsl_state_t;

  // received device-phase byte
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } swsl_rx_t;

  // one speed's timing set, in cycles
  typedef struct packed {
    logic [15:0] rst_det;
    logic [15:0] pres_delay;
    logic [15:0] pres_low;
    logic [15:0] sample;
    logic [15:0] drive;
  } swsl_timing_t;

endpackage

// ===== testbench/swsl_master_model.sv
// bus master model: reset pulses and one-bit slots on the pulled-up wire
module swsl_master_model (
  input wire logic i_clk,
  input wire logic i_oe_n,
  output logic o_line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic master_low = 1'b0;
  int pres_wait;
  int pres_len;
  // wired-and with pull-up: we start every fall, the slave only the presence
  assign o_line = !master_low && i_oe_n;
  // reset pulse, then time the presence and sit out the whole high interval
  task automatic bus_reset(input int len, input int hold);
    @(negedge i_clk) master_low = 1'b1;
    repeat (len) @(negedge i_clk);
    master_low = 1'b0;
    pres_wait = 0;
    pres_len = 0;
    for (int n = 0; n < hold; n++) begin
      @(negedge i_clk);
      if (i_oe_n && pres_len == 0) pres_wait++;
      else if (!i_oe_n) pres_len++;
    end
  endtask
  // one slot: low time, sample point, then recovery up to the slot end
  task automatic slot(input int low, input int samp, input int len, output logic seen);
    @(negedge i_clk) master_low = 1'b1;
    for (int n = 1; n < len; n++) begin
      @(negedge i_clk);
      if (n == low) master_low = 1'b0;
      if (n == samp) seen = o_line;
    end
  endtask
endmodule

// ===== testbench/swsl_slave_asserts.sv
// concurrent checks on the ports of the single-wire slave front end
module swsl_slave_asserts #(
  parameter int unsigned RST_EXIT_CYC = 48000,
  parameter int unsigned RST_DET_STD_CYC = 24000,
  parameter int unsigned PDL_STD_CYC = 12000
) (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_line,
  input wire logic i_tx_bit,
  input wire logic o_line_oe_n,
  input wire logic o_tx_taken,
  input wire swsl_pkg::swsl_rx_t o_rx,
  input wire logic o_dev_active,
  input wire logic o_fast_speed_flag,
  input wire logic o_reset_seen
);
  import swsl_pkg::*;
  localparam int MIN_DET = (RST_DET_STD_CYC < 4800) ? RST_DET_STD_CYC : 4800;
  localparam int MAX_PULL = (PDL_STD_CYC > 4000) ? PDL_STD_CYC + 2 : 4002;
  int pull_run;
  int next_pull_run;
  int line_run;
  int next_line_run;
  logic line_q;
  // length of our own pull, and of the last low run on the wire
  always_comb begin
    next_pull_run = o_line_oe_n ? 0 : pull_run + 1;
    next_line_run = line_run;
    if (!i_line) next_line_run = line_q ? 1 : line_run + 1;
  end
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pull_run <= 0;
      line_run <= 0;
      line_q <= 1'b1;
    end else begin
      pull_run <= next_pull_run;
      line_run <= next_line_run;
      line_q <= i_line;
    end
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  a_reset_low_min: assert property (o_reset_seen |-> line_run >= MIN_DET - 1)
    else $error("reset seen after a short low");
  a_exit_clears: assert property (o_reset_seen && line_run >= RST_EXIT_CYC + 2 |-> ##[0:2] !o_fast_speed_flag)
    else $error("long reset left fast speed set");
  a_keep_fast: assert property (o_reset_seen && $past(o_fast_speed_flag) && line_run < RST_EXIT_CYC - 2
    |-> o_fast_speed_flag [*3])
    else $error("short reset dropped fast speed");
  a_pres_wait: assert property (o_reset_seen |-> o_line_oe_n [*8])
    else $error("presence without delay");
  a_dev_drop: assert property (o_reset_seen |=> !o_dev_active)
    else $error("device phase kept over reset");
  a_rx_in_dev: assert property (o_rx.valid |-> o_dev_active)
    else $error("byte delivered outside device phase");
  a_read_zero: assert property (o_tx_taken && !$past(i_tx_bit) && o_dev_active |-> !o_line_oe_n [*8])
    else $error("read zero not pulled");
  a_read_one: assert property (o_tx_taken && $past(i_tx_bit) |-> o_line_oe_n [*8])
    else $error("read one pulled the wire");
  a_tx_in_dev: assert property (o_tx_taken |-> o_dev_active)
    else $error("answer bit outside device phase");
  a_pull_bounded: assert property (pull_run <= MAX_PULL)
    else $error("pull held too long");
  cover property (o_reset_seen && $past(o_fast_speed_flag));
  cover property ($rose(o_dev_active));
  cover property (o_tx_taken && !$past(i_tx_bit));
  cover property (o_rx.valid);
endmodule
bind swsl_slave swsl_slave_asserts #(.RST_EXIT_CYC(RST_EXIT_CYC), .RST_DET_STD_CYC(RST_DET_STD_CYC),
  .PDL_STD_CYC(PDL_STD_CYC)) swsl_slave_asserts_i (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_line(i_line),
  .i_tx_bit(i_tx_bit), .o_line_oe_n(o_line_oe_n), .o_tx_taken(o_tx_taken), .o_rx(o_rx),
  .o_dev_active(o_dev_active), .o_fast_speed_flag(o_fast_speed_flag), .o_reset_seen(o_reset_seen));

// ===== testbench/tb.sv
// self-checking bench for the single-wire slave front end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import swsl_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic i_tx_en = 1'b0;
  logic i_tx_bit = 1'b0;
  logic [63:0] i_rom_id = 64'h0;
  logic i_line, o_line_oe_n, o_tx_taken, o_dev_active, o_fast_speed_flag, o_resume_select_flag, o_reset_seen;
  logic o_line_out;
  swsl_rx_t o_rx;
  int error_cnt = 0;
  int tests_run = 0;
  int seed = 32'h392d;
  int exp_fast = 0;
  int exp_rc = 0;
  int exp_dev = 0;
  int rst_n = 0;
  int tx_n = 0;
  logic [7:0] rx_q[$];
  logic [7:0] dbyte;
  logic seen;
  always #5 i_ref_clk = !i_ref_clk;
  swsl_slave #(.RST_EXIT_CYC(6000), .RST_DET_STD_CYC(4500), .PDL_STD_CYC(240)) swsl_slave_i (
    .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_ce(1'b1), .i_line(i_line), .o_line_out(o_line_out),
    .o_line_oe_n(o_line_oe_n), .i_rom_id(i_rom_id), .i_tx_en(i_tx_en), .i_tx_bit(i_tx_bit),
    .o_tx_taken(o_tx_taken), .o_rx(o_rx), .o_dev_active(o_dev_active), .o_fast_speed_flag(o_fast_speed_flag),
    .o_resume_select_flag(o_resume_select_flag), .o_reset_seen(o_reset_seen));
  swsl_master_model swsl_master_model_i (.i_clk(i_ref_clk), .i_oe_n(o_line_oe_n), .o_line(i_line));
  // pulse counters and received bytes
  always @(posedge i_ref_clk) begin
    if (o_reset_seen === 1'b1) rst_n++;
    if (o_tx_taken === 1'b1) tx_n++;
    if (o_rx.valid === 1'b1) rx_q.push_back(o_rx.data);
  end
  ////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic flags();
    check("fast", o_fast_speed_flag, exp_fast[0]);
    check("resume", o_resume_select_flag, exp_rc[0]);
    check("dev", o_dev_active, exp_dev[0]);
  endtask
  task automatic finish_test();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // reset at the length given; only 6000 cycles or more leaves fast speed
  task automatic bus_rst(input int len);
    int pd;
    int pl;
    int n0;
    n0 = rst_n;
    if (len >= 6000) exp_fast = 0;
    pd = exp_fast ? 300 : 3000;
    pl = exp_fast ? 1200 : 240;
    swsl_master_model_i.bus_reset(len, pd + pl + 10);
    exp_dev = 0;
    check("reset", rst_n - n0, 1);
    check("pres_wait", swsl_master_model_i.pres_wait inside {[pd:pd + 4]}, 1);
    check("pres_len", swsl_master_model_i.pres_len inside {[pl:pl + 2]}, 1);
    flags();
  endtask
  task automatic send_bit(input logic b);
    int sl;
    logic s;
    sl = exp_fast ? 305 : 3005;
    swsl_master_model_i.slot(b ? 5 : sl - 3, 0, sl, s);
  endtask
  task automatic send_byte(input logic [7:0] b);
    for (int k = 0; k < 8; k++) send_bit(b[k]);
  endtask
  task automatic rd(input logic b);
    i_tx_en = 1'b1;
    i_tx_bit = b;
    swsl_master_model_i.slot(3, 100, 410, seen);
    check("read", seen, b);
  endtask
  // main sequence: standard reset, fast skip, fast match, resume, data, skip, match, exit
  initial begin
    i_rom_id = {$random(seed), $random(seed)};
    repeat (16) @(negedge i_ref_clk);
    i_rstn = 1'b1;
    flags();
    check("line_out", o_line_out, 1'b0);
    bus_rst(4510);
    send_byte(8'h3c);
    exp_fast = 1;
    exp_dev = 1;
    flags();
    bus_rst(4850);
    send_byte(8'h69);
    for (int k = 0; k < 64; k++) send_bit(i_rom_id[k]);
    exp_rc = 1;
    exp_dev = 1;
    flags();
    bus_rst(4850);
    send_byte(8'ha5);
    exp_dev = 1;
    flags();
    rx_q.delete();
    dbyte = 8'($random(seed));
    send_byte(dbyte);
    check("rx_cnt", rx_q.size(), 1);
    check("rx", rx_q[0], dbyte);
    rd(1'b0);
    rd(1'b1);
    i_tx_en = 1'b0;
    check("tx_taken", tx_n, 2);
    bus_rst(4850);
    send_byte(8'hcc);
    exp_rc = 0;
    exp_dev = 1;
    flags();
    // match command waits for the identifier, so no device phase yet
    bus_rst(4850);
    send_byte(8'h55);
    flags();
    bus_rst(6010);
    finish_test();
  end
  // hang guard
  initial begin
    repeat (100000) @(posedge i_ref_clk);
    error_cnt++;
    finish_test();
  end
endmodule
